// ===== src/keypad_regs_consts.vh
/*
 Constants for the keypad, pin and converter register bank.
 Assumes inclusion by bare name from design files under src/.
*/
`ifndef KEYPAD_REGS_CONSTS_VH
`define KEYPAD_REGS_CONSTS_VH

`define CMD_READ_BIT        15
`define REG_IDX_W           6
`define REG_CONV_CODE       6'h0b
`define REG_PIN_DATA        6'h0f
`define REG_KEY_PENDING     6'h10
`define REG_KEY_STATUS      6'h11
`define REG_CONV_CTRL       6'h00
`define CONV_CODE_RESET     16'h1000
`define DATA_RESET          16'h0000
`define PIN_FIELD_LO        8
`define CTRL_RES_LO         8
`define CTRL_RES_HI         9
`define CTRL_SCAN_LO        12
`define CTRL_AVG_LO         2
`define CTRL_SETTLE_LO      4
`define CTRL_RESET          16'h0000
`define REF_UP_TIME_NS      31000
`define SETTLE_MAX_TIME_MS  100
`define CLK_PERIOD_NS       5
`define RES_8BIT            2'h0
`define RES_10BIT           2'h1
`define RES_12BIT           2'h2

`endif

// ===== src/pin_sync.v
/*
 Three-stage synchroniser with agreement filter for a bus of pins.
 Assumes inputs come from outside the core clock domain.
*/
`timescale 1ns/100ps
module pin_sync #(
   parameter W = 8
) (
   input  wire         core_clk_i,  // Core clock
   input  wire         rst_n_i,     // Synchronised reset, active low
   input  wire [W-1:0] pin_i,       // Asynchronous pin levels
   output reg  [W-1:0] level_o      // Filtered level
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q    <= {W{1'b0}};
         s2_q    <= {W{1'b0}};
         s3_q    <= {W{1'b0}};
         level_o <= {W{1'b0}};
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // Change is accepted only when stages two and three agree
         level_o <= (s2_q & s3_q) | (level_o & (s2_q | s3_q));
      end
   end
endmodule // pin_sync

// ===== src/keypad_gpio_dac_adc_config_regs.v
/*
 Register bank of a touch-screen and keypad controller: masked and pending
 key words, converter output code, general pin data, converter control with
 resolution, averaging and settling fields, reference-up and settle timers.
 Assumes a serial front end delivers decoded 16-bit command and data words
 as one-cycle strobes, and a scan engine supplies key results and masks.
 Register indices: 0x00 converter control, 0x0b converter code, 0x0f pin
 data, 0x10 pending keys, 0x11 masked keys; bit 15 of the command selects
 a read. Writes to other indices are dropped and reads of them give zero.
 The converter code register keeps only its low byte live, so a read of it
 never shows the upper-byte reset pattern.
*/
//
// Behaviour
// - Masked status: key or column mask suppresses
// - Key bit index is 4*(col-1)+(row-1)
// - Converter code in bits 7..0, upper zero
// - Commands 0x000B write, 0x800B read code
// - Pin data in bits 15..8, low zero
// - Commands 0x000F write, 0x800F read pins
// - Pin data read returns sampled pin levels
// - Pin data write drives configured output pins
// - Writes to non-output pins are discarded
// - Results are unsigned straight binary codes
// - Resolution field selects 8, 10, 12 bits
// - Power-up resolution 8 bits, 31us reference delay
// - Scan field zero: resolution bits control reference
// - Programmable touch settling delay up to 100ms
// - Averaging field selects conversion averaging
// - Drive switches closed during acquire and convert
// - Y measure: references routed to Y plates
// - Pending word honours column masks only
// - Data registers reset zero, code resets 0x1000
`timescale 1ns/100ps
`include "keypad_regs_consts.vh"
module keypad_gpio_dac_adc_config_regs #(
   parameter SETTLE_STEP_CYCLES = 32'd1250000,   // Cycles per settling code step
   parameter REF_UP_CYCLES      = 32'd6200       // Reference power-up delay
) (
   input  wire        core_clk_i,        // 200 MHz core clock
   input  wire        resetn_i,          // Asynchronous reset, active low
   input  wire        cmd_valid_i,       // One-cycle command strobe
   input  wire [15:0] cmd_word_i,        // Command word, bit 15 selects read
   input  wire [15:0] wr_data_i,         // Write data with the command
   output reg         rd_valid_o,        // Read data valid pulse
   output reg  [15:0] rd_data_o,         // Read data word
   input  wire [15:0] key_result_i,      // Debounced scan result, column-major
   input  wire [15:0] key_mask_i,        // Per-key mask, 1 masks
   input  wire [3:0]  col_mask_i,        // Per-column mask, 1 masks
   input  wire [7:0]  pin_gp_sel_i,      // Pin is general purpose
   input  wire [7:0]  pin_oe_sel_i,      // General pin is an output
   input  wire [7:0]  pin_in_i,          // Row and column pin levels
   output reg  [7:0]  pin_out_o,         // Pin output values
   output reg  [7:0]  pin_oe_o,          // Pin output enables
   output reg  [7:0]  conv_code_o,       // Converter output code
   input  wire        touch_det_i,       // Screen touch detected
   input  wire        conv_busy_i,       // Acquisition or conversion running
   input  wire        meas_y_i,          // Current measurement is Y
   input  wire [11:0] adc_raw_i,         // Raw 12-bit straight binary result
   output reg  [11:0] adc_result_o,      // Result truncated to resolution
   output reg  [1:0]  resolution_o,      // Active resolution code
   output reg  [1:0]  avg_sel_o,         // Averaging selection
   output reg         ref_ready_o,       // Reference powered and settled
   output reg         scan_start_o,      // Touch scan start pulse
   output reg         switch_drive_o,    // Plate drive switches closed
   output reg         ref_to_y_o         // References routed to Y plates
);
   reg        rst_m_q;
   reg        rst_n_q;
   reg [15:0] conv_code_q;
   reg [7:0]  pin_drive_q;
   reg [15:0] ctrl_q;
   reg [31:0] ref_cnt_q;
   reg [31:0] settle_cnt_q;
   reg [3:0]  settle_step_q;
   reg        settling_q;
   reg [1:0]  ref_state_q;
   reg        touch_q;
   wire [7:0]  pin_level;
   wire [15:0] col_ok;
   wire [15:0] pending_word;
   wire [15:0] status_word;
   wire [15:0] pin_word;
   wire        is_read;
   wire [5:0]  reg_idx;
   wire [3:0]  scan_sel;
   wire [1:0]  res_bits;
   wire [7:0]  out_en;
   reg  [15:0] rd_mux;
   reg  [11:0] res_trunc;
   wire        rd_take;
   wire        wr_code;
   wire        wr_pin;
   wire        wr_ctrl;

   localparam REF_IDLE = 2'h0;
   localparam REF_WAIT = 2'h1;
   localparam REF_UP   = 2'h2;

   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   pin_sync #(
      .W(8)
   ) u_pin_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_q),
      .pin_i      (pin_in_i),
      .level_o    (pin_level)
   );

   genvar k;
   generate
      for (k = 0; k < 16; k = k + 1) begin : g_key
         // Bit k belongs to column k/4, row k%4
         assign col_ok[k] = ~col_mask_i[k/4];
         assign pending_word[k] = key_result_i[k] & col_ok[k];
         assign status_word[k] = key_result_i[k] & col_ok[k]
                                 & ~key_mask_i[k];
      end
   endgenerate

   assign is_read  = cmd_word_i[`CMD_READ_BIT];
   assign reg_idx  = cmd_word_i[`REG_IDX_W-1:0];
   assign out_en   = pin_gp_sel_i & pin_oe_sel_i;
   assign pin_word = {pin_level, 8'h00};
   assign scan_sel = ctrl_q[`CTRL_SCAN_LO+3:`CTRL_SCAN_LO];
   assign res_bits = ctrl_q[`CTRL_RES_HI:`CTRL_RES_LO];
   // Writes to any other index, the key words included, are dropped
   assign rd_take  = cmd_valid_i & is_read;
   assign wr_code  = cmd_valid_i & ~is_read & (reg_idx == `REG_CONV_CODE);
   assign wr_pin   = cmd_valid_i & ~is_read & (reg_idx == `REG_PIN_DATA);
   assign wr_ctrl  = cmd_valid_i & ~is_read & (reg_idx == `REG_CONV_CTRL);

   always @* begin
      case (reg_idx)
         `REG_CONV_CODE:   rd_mux = {8'h00, conv_code_q[7:0]};
         `REG_PIN_DATA:    rd_mux = pin_word;
         `REG_KEY_PENDING: rd_mux = pending_word;
         `REG_KEY_STATUS:  rd_mux = status_word;
         `REG_CONV_CTRL:   rd_mux = ctrl_q;
         default:          rd_mux = 16'h0000;
      endcase
   end

   // Read answer: the word is taken from the mux at the edge that takes the command
   always @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_valid_o <= 1'b0;
         rd_data_o  <= `DATA_RESET;
      end else begin
         rd_valid_o <= rd_take;
         if (rd_take) begin
            rd_data_o <= rd_mux;
         end
      end
   end

   always @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         conv_code_q <= `CONV_CODE_RESET;
         conv_code_o <= 8'h00;
      end else begin
         if (wr_code) begin
            conv_code_q <= {8'h00, wr_data_i[7:0]};
         end
         conv_code_o <= conv_code_q[7:0];
      end
   end

   always @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctrl_q <= `CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= wr_data_i;
      end
   end

   // Bits of pins that are not outputs are never held, so a pin that later
   // turns into an output cannot show a stale written value
   always @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_drive_q <= 8'h00;
         pin_out_o   <= 8'h00;
         pin_oe_o    <= 8'h00;
      end else begin
         if (wr_pin) begin
            pin_drive_q <= wr_data_i[15:`PIN_FIELD_LO] & out_en;
         end else begin
            pin_drive_q <= pin_drive_q & out_en;
         end
         pin_out_o <= pin_drive_q & out_en;
         pin_oe_o  <= out_en;
      end
   end

   // Resolution truncation keeps straight binary, dropping low bits
   always @* begin
      case (resolution_o)
         `RES_8BIT:  res_trunc = {4'h0, adc_raw_i[11:4]};
         `RES_10BIT: res_trunc = {2'h0, adc_raw_i[11:2]};
         `RES_12BIT: res_trunc = adc_raw_i;
         // Code 3 is unassigned and falls back to full width
         default:    res_trunc = adc_raw_i;
      endcase
   end

   always @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         resolution_o   <= `RES_8BIT;
         avg_sel_o      <= 2'h0;
         adc_result_o   <= 12'h000;
         switch_drive_o <= 1'b0;
         ref_to_y_o     <= 1'b0;
      end else begin
         // Scan field zero: the bits govern reference power, not width
         if (scan_sel != 4'h0) begin
            resolution_o <= res_bits;
         end
         avg_sel_o      <= ctrl_q[`CTRL_AVG_LO+1:`CTRL_AVG_LO];
         adc_result_o   <= res_trunc;
         switch_drive_o <= conv_busy_i;
         ref_to_y_o     <= conv_busy_i & meas_y_i;
      end
   end

   // Reference power-up timer, armed from power-up and, after a power-down, when scan field zero has resolution bits other than 3
   always @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ref_state_q <= REF_WAIT;
         ref_cnt_q   <= 32'd0;
         ref_ready_o <= 1'b0;
      end else begin
         case (ref_state_q)
            REF_IDLE: begin
               ref_ready_o <= 1'b0;
               if (scan_sel == 4'h0 && res_bits != 2'h3) begin
                  ref_cnt_q   <= 32'd0;
                  ref_state_q <= REF_WAIT;
               end
            end
            REF_WAIT: begin
               // A power-down request also cancels a reference still warming up
               if (scan_sel == 4'h0 && res_bits == 2'h3) begin
                  ref_state_q <= REF_IDLE;
               end else if (ref_cnt_q >= REF_UP_CYCLES - 32'd1) begin
                  ref_state_q <= REF_UP;
                  ref_ready_o <= 1'b1;
               end else begin
                  ref_cnt_q <= ref_cnt_q + 32'd1;
               end
            end
            REF_UP: begin
               if (scan_sel == 4'h0 && res_bits == 2'h3) begin
                  ref_state_q <= REF_IDLE;
                  ref_ready_o <= 1'b0;
               end
            end
            default: ref_state_q <= REF_IDLE;
         endcase
      end
   end

   // Settling delay: code times SETTLE_STEP_CYCLES after the touch edge;
   // the largest code, fifteen steps, stays inside the longest allowed delay
   always @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         touch_q       <= 1'b0;
         settling_q    <= 1'b0;
         settle_cnt_q  <= 32'd0;
         settle_step_q <= 4'h0;
         scan_start_o  <= 1'b0;
      end else begin
         touch_q      <= touch_det_i;
         scan_start_o <= 1'b0;
         if (touch_det_i & ~touch_q & ~settling_q) begin
            settle_step_q <= ctrl_q[`CTRL_SETTLE_LO+3:`CTRL_SETTLE_LO];
            settle_cnt_q  <= 32'd0;
            settling_q    <= 1'b1;
         end else if (settling_q) begin
            if (settle_step_q == 4'h0) begin
               settling_q   <= 1'b0;
               scan_start_o <= 1'b1;
            end else if (settle_cnt_q >= SETTLE_STEP_CYCLES - 32'd1) begin
               settle_cnt_q  <= 32'd0;
               settle_step_q <= settle_step_q - 4'h1;
            end else begin
               settle_cnt_q <= settle_cnt_q + 32'd1;
            end
         end
      end
   end
endmodule // keypad_gpio_dac_adc_config_regs

// ===== testbench/regs_props.sv
/* Port assertions for the keypad, pin and converter register bank.
   Assumes it is bound onto the bank's top module. */
`timescale 1ns/100ps
module regs_props (
   input wire        core_clk_i,     // Clock
   input wire        resetn_i,       // Reset, active low
   input wire        cmd_valid_i,    // Strobe
   input wire [15:0] cmd_word_i,     // Command
   input wire        rd_valid_o,     // Answer
   input wire [15:0] rd_data_o,      // Read data
   input wire [15:0] key_result_i,   // Keys
   input wire [15:0] key_mask_i,     // Key masks
   input wire [3:0]  col_mask_i,     // Column masks
   input wire [7:0]  pin_gp_sel_i,   // General pin select
   input wire [7:0]  pin_oe_sel_i,   // General pin output select
   input wire [7:0]  pin_out_o,      // Pin values
   input wire [7:0]  pin_oe_o,       // Pin enables
   input wire        conv_busy_i,    // Busy
   input wire        meas_y_i,       // Y phase
   input wire        switch_drive_o, // Switches
   input wire        ref_to_y_o,     // Y routing
   input wire        scan_start_o    // Scan pulse
);
   wire [15:0] colx = {{4{col_mask_i[3]}}, {4{col_mask_i[2]}}, {4{col_mask_i[1]}},
                       {4{col_mask_i[0]}}};
   wire [15:0] exp_status  = key_result_i & ~key_mask_i & ~colx;
   wire [15:0] exp_pending = key_result_i & ~colx;
   wire        busy_y      = conv_busy_i & meas_y_i;
   wire [7:0]  out_en      = pin_gp_sel_i & pin_oe_sel_i;
   wire        rd   = cmd_valid_i & cmd_word_i[15];
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   AST_RD_ANSWER: assert property (rd |=> rd_valid_o) else $error("read unanswered");
   AST_NO_ANSWER: assert property (!rd |=> !rd_valid_o) else $error("stray answer");
   AST_CODE_FMT: assert property (cmd_valid_i && cmd_word_i == 16'h800b
      |=> rd_data_o[15:8] == 8'h00) else $error("code upper bits set");
   AST_PIN_FMT: assert property (cmd_valid_i && cmd_word_i == 16'h800f
      |=> rd_data_o[7:0] == 8'h00) else $error("pin low bits set");
   AST_STATUS: assert property (cmd_valid_i && cmd_word_i == 16'h8011
      |=> rd_data_o == $past(exp_status)) else $error("status");
   AST_PENDING: assert property (cmd_valid_i && cmd_word_i == 16'h8010
      |=> rd_data_o == $past(exp_pending)) else $error("pending");
   AST_PIN_HELD: assert property ((pin_out_o & ~pin_oe_o) == 8'h00) else $error("kept");
   AST_PIN_OE: assert property (##1 pin_oe_o == $past(out_en)) else $error("pin enable");
   AST_SWITCH: assert property (##1 switch_drive_o == $past(conv_busy_i)) else $error("sw");
   AST_Y_ROUTE: assert property (##1 ref_to_y_o == $past(busy_y))
      else $error("y routing");
   AST_SCAN_PULSE: assert property (scan_start_o |=> !scan_start_o) else $error("long");
endmodule // regs_props

// ===== testbench/host_model.sv
/* Host command model: issues one 16-bit word per command.
   Assumes the bank registers a read answer on the taken edge itself. */
`timescale 1ns/100ps
module host_model (
   input  wire        core_clk_i,  // Clock
   output reg         cmd_valid_o, // Strobe
   output reg  [15:0] cmd_word_o,  // Command
   output reg  [15:0] wr_data_o,   // Write data
   input  wire        rd_valid_i,  // Answer
   input  wire [15:0] rd_data_i    // Read data
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_word_o = 16'h0;
      wr_data_o = 16'h0;
   end
   task xfer(input [15:0] w, input [15:0] d, output [15:0] r);
      begin
         repeat (1 + $urandom % 3) @(posedge core_clk_i);
         #1 cmd_valid_o = 1'b1;
         cmd_word_o = w;
         wr_data_o = d;
         @(posedge core_clk_i);
         #1 cmd_valid_o = 1'b0;
         // Released lines show the inverse so stale values cannot pass
         cmd_word_o = ~w;
         wr_data_o = ~d;
         r = (rd_valid_i === 1'b1) ? rd_data_i : 16'hxxxx;
      end
   endtask
endmodule // host_model

// ===== testbench/testbench.sv
/* Self-checking bench for the register bank.
   Assumes host_model and regs_props are compiled first. */
`timescale 1ns/100ps
module testbench;
   reg         core_clk_i = 1'b0;
   reg         resetn_i = 1'b0;
   reg  [15:0] key_r = 16'h0, key_m = 16'h0, d, r;
   reg  [3:0]  col_m = 4'h0;
   reg  [7:0]  gp = 8'h0, oe = 8'h0, ext = 8'h0, om;
   reg         touch = 1'b0, busy = 1'b0, my = 1'b0;
   reg  [11:0] raw = 12'h0;
   wire        cv, rv, rr, ss, sw, ry;
   wire [15:0] cw, wd, rdat;
   wire [7:0]  po, poe, code;
   wire [11:0] adc;
   wire [1:0]  res, avg;
   wire [7:0]  pin_w = (po & poe) | (ext & ~poe);
   integer     err_total = 0, samples_checked = 0, i, n, s;
   localparam [31:0] STEP = 32'd4;
   localparam [31:0] REF_UP = 32'd8;
   always #2.5 core_clk_i = ~core_clk_i;
   host_model host_u (.core_clk_i(core_clk_i), .cmd_valid_o(cv), .cmd_word_o(cw),
      .wr_data_o(wd), .rd_valid_i(rv), .rd_data_i(rdat));
   keypad_gpio_dac_adc_config_regs #(.SETTLE_STEP_CYCLES(STEP), .REF_UP_CYCLES(REF_UP)) dut_u (
      .core_clk_i(core_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cv), .cmd_word_i(cw),
      .wr_data_i(wd), .rd_valid_o(rv), .rd_data_o(rdat), .key_result_i(key_r),
      .key_mask_i(key_m), .col_mask_i(col_m), .pin_gp_sel_i(gp), .pin_oe_sel_i(oe),
      .pin_in_i(pin_w), .pin_out_o(po), .pin_oe_o(poe), .conv_code_o(code),
      .touch_det_i(touch), .conv_busy_i(busy), .meas_y_i(my), .adc_raw_i(raw),
      .adc_result_o(adc), .resolution_o(res), .avg_sel_o(avg), .ref_ready_o(rr),
      .scan_start_o(ss), .switch_drive_o(sw), .ref_to_y_o(ry));
   function [15:0] kexp(input [15:0] k, input [15:0] m, input [3:0] c, input use_m);
      integer ro, co;
      begin
         kexp = 16'h0;
         for (co = 1; co <= 4; co = co + 1)
            for (ro = 1; ro <= 4; ro = ro + 1)
               kexp[4*(co-1)+(ro-1)] = k[4*(co-1)+(ro-1)] & ~c[co-1]
                                       & ~(use_m & m[4*(co-1)+(ro-1)]);
      end
   endfunction
   task chk(input string nm, input [15:0] ex, input [15:0] got);
      begin
         samples_checked = samples_checked + 1;
         if (got !== ex) begin
            err_total = err_total + 1;
            $display("[FAIL] %0s exp %h got %h", nm, ex, got);
         end
      end
   endtask
   task tick(input integer k);
      begin
         repeat (k) @(posedge core_clk_i);
         #1;
      end
   endtask
   task close_out;
      begin
         if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial begin
      #50000;
      err_total = err_total + 1;
      close_out;
   end
   initial begin
      n = $urandom(14);
      tick(6);
      resetn_i = 1'b1;
      tick(3);
      chk("res_rst", 16'h0, {14'h0, res});
      chk("ref_wait", 16'h0, {15'h0, rr});
      host_u.xfer(16'h800b, 16'h0, r);
      chk("code_rst", 16'h0, r);
      host_u.xfer(16'h803f, 16'h0, r);
      chk("unmapped", 16'h0, r);
      tick(REF_UP + 12);
      chk("ref_up", 16'h1, {15'h0, rr});
      for (i = 0; i < 20; i = i + 1) begin
         d = (i == 0) ? 16'hffff : $urandom;
         host_u.xfer(16'h000b, d, r);
         host_u.xfer(16'h800b, 16'h0, r);
         chk("code_rd", {8'h00, d[7:0]}, r);
         chk("code_o", {8'h00, d[7:0]}, {8'h00, code});
      end
      host_u.xfer(16'h0011, 16'hffff, r);
      for (i = 0; i < 40; i = i + 1) begin
         key_r = $urandom;
         key_m = $urandom;
         col_m = (i < 4) ? (4'h1 << i) : $urandom;
         busy = $urandom;
         my = $urandom;
         host_u.xfer(16'h8011, 16'h0, r);
         chk("status", kexp(key_r, key_m, col_m, 1'b1), r);
         host_u.xfer(16'h8010, 16'h0, r);
         chk("pending", kexp(key_r, key_m, col_m, 1'b0), r);
      end
      for (i = 0; i < 20; i = i + 1) begin
         gp = (i == 0) ? 8'hff : $urandom;
         oe = (i == 0) ? 8'hff : $urandom;
         ext = $urandom;
         d = $urandom;
         host_u.xfer(16'h000f, d, r);
         tick(6);
         chk("pin_oe", {8'h0, gp & oe}, {8'h0, poe});
         chk("pin_out", {8'h0, d[15:8] & gp & oe}, {8'h0, po});
         host_u.xfer(16'h800f, 16'h0, r);
         chk("pin_rd", {pin_w, 8'h00}, r);
         om = gp & oe;
         gp = 8'hff;
         oe = 8'hff;
         tick(3);
         chk("pin_discard", {8'h0, d[15:8] & om}, {8'h0, po});
         oe = 8'h00;
         tick(3);
         oe = 8'hff;
         tick(3);
         chk("pin_drop", 16'h0, {8'h0, po});
      end
      for (i = 0; i < 3; i = i + 1) begin
         raw = $urandom;
         s = $urandom % 4;
         host_u.xfer(16'h0000, {4'h1, 2'h0, i[1:0], 4'h0, s[1:0], 2'h0}, r);
         tick(4);
         chk("res", i, {14'h0, res});
         chk("avg", s, {14'h0, avg});
         chk("adc", {4'h0, raw >> (4 - 2 * i)}, {4'h0, adc});
      end
      host_u.xfer(16'h0000, 16'h0300, r);
      tick(4);
      chk("res_hold", 16'h2, {14'h0, res});
      chk("ref_down", 16'h0, {15'h0, rr});
      host_u.xfer(16'h0000, 16'h0000, r);
      tick(2);
      chk("ref_rearm", 16'h0, {15'h0, rr});
      tick(REF_UP + 4);
      chk("ref_back", 16'h1, {15'h0, rr});
      for (i = 0; i < 2; i = i + 1) begin
         host_u.xfer(16'h0000, {4'h1, 4'h0, i[0] ? 4'h3 : 4'h0, 4'h0}, r);
         touch = 1'b1;
         n = 0;
         while (ss !== 1'b1 && n < 100) begin
            tick(1);
            n = n + 1;
         end
         s = 3 * i * STEP;
         chk("settle", 16'h1, {15'h0, n >= s + 1 && n <= s + 4});
         touch = 1'b0;
         tick(2);
      end
      close_out;
   end
endmodule // testbench
bind keypad_gpio_dac_adc_config_regs regs_props props_u (.core_clk_i(core_clk_i),
   .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i), .cmd_word_i(cmd_word_i),
   .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .key_result_i(key_result_i),
   .key_mask_i(key_mask_i), .col_mask_i(col_mask_i), .pin_gp_sel_i(pin_gp_sel_i),
   .pin_oe_sel_i(pin_oe_sel_i), .pin_out_o(pin_out_o),
   .pin_oe_o(pin_oe_o), .conv_busy_i(conv_busy_i), .meas_y_i(meas_y_i),
   .switch_drive_o(switch_drive_o), .ref_to_y_o(ref_to_y_o), .scan_start_o(scan_start_o));
